// ---- hw/bpc_cfg.svh ----
// Constants of the banked program counter
//
// Overview of operation
// - Program address is extended by bank-select bit from output latch bit 3.
// - Bank-select bit changes only on the write-output-port-A instruction.
// - Sequential, jump or call flow never crosses banks on its own.
// - Twelve-bit program counter covers 4096 locations in the chosen bank.
// - After fetch the counter advances by one or two per instruction length.
// - Each transfer loads the counter with its own address.
// - Jump or call loads all twelve bits; bank bit unchanged.
// - Taken conditional branch keeps top bit, loads lower eleven bits.
// - Return loads twelve bits from the stack; bank bit unchanged.
// - Reset starts at 1000H: bank bit one, counter zero.
// - Timer interrupt loads offset 0004H in current bank.
// - External halt interrupt calls offset 8 in current bank.
// - Interrupt pushes counter and carry; call pushes counter only.
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH
`define BPC_PC_W        12
`define BPC_BANK_BIT    3
`define BPC_RESET_BANK  1'b1
`define BPC_RESET_PC    12'h000
`define BPC_TIMER_VEC   12'h004
`define BPC_EXT_VEC     12'h008
`endif

// ---- hw/bpc_pkg.sv ----
// Types of the banked program counter
`include "bpc_cfg.svh"
package bpc_pkg;
  typedef enum logic [2:0] {
    BPC_OP_SEQ   = 3'b000,
    BPC_OP_JUMP  = 3'b001,
    BPC_OP_COND  = 3'b010,
    BPC_OP_RET   = 3'b011,
    BPC_OP_RETURN_FROM_INTERRUPT  = 3'b100,
    BPC_OP_TIMER = 3'b101,
    BPC_OP_EXT   = 3'b110
  } bpc_op_t;
  typedef struct packed {
    bpc_op_t                  op;
    logic                     push;
    logic                     two_word;
    logic                     taken;
    logic [`BPC_PC_W-1:0]     target;
  } bpc_cmd_t;
  typedef struct packed {
    logic [`BPC_PC_W-1:0] pc;
    logic                 carry;
  } bpc_stack_t;
endpackage

// ---- hw/bpc_stack.sv ----
// One-level return stack holding counter and carry
`timescale 1ns/1ns
`default_nettype none
module bpc_stack
  import bpc_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic       push,     // Save entry
  input  wire logic       keep_c,   // Save carry too
  input  wire bpc_stack_t wdata,    // Entry to save
  output var  bpc_stack_t rdata     // Saved entry, registered
);
  bpc_stack_t ent_r, ent_nxt;

  // Call keeps old carry slot; interrupt stores the carry
  always_comb begin
    ent_nxt = ent_r;
    if (push) begin
      ent_nxt.pc = wdata.pc;
      if (keep_c) ent_nxt.carry = wdata.carry;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ent_r <= '0;
    else ent_r <= ent_nxt;
  end

  assign rdata = ent_r;
endmodule
`default_nettype wire

// ---- hw/bpc_top.sv ----
// Banked program counter with vectors and one-level stack
`timescale 1ns/1ns
`default_nettype none
`include "bpc_cfg.svh"
module bpc_top
  import bpc_pkg::*;
(
  input  wire logic           clk,             // System clock, 250 MHz
  input  wire logic           rst_n,           // Async reset, active low
  input  wire logic           cycle_en,        // Instruction-cycle boundary pulse
  input  wire bpc_cmd_t       cmd,             // Next-address command
  input  wire logic           write_output_port_a, // Port A write this cycle
  input  wire logic [3:0]     acc,             // Accumulator value
  input  wire logic           carry_in,        // Current carry flag
  output logic [`BPC_PC_W:0]  rom_addr,        // Bank bit and counter
  output logic [`BPC_PC_W-1:0] program_counter, // Counter value
  output logic                rom_bank_select, // Bank-select bit
  output logic                carry_restore,   // Carry to reload on interrupt return
  output logic                carry_restore_vld // One-cycle restore strobe
);
  logic [`BPC_PC_W-1:0] pc_r, pc_nxt;
  logic                 bank_r, bank_nxt;
  logic                 cr_r, cr_nxt, crv_r, crv_nxt;
  logic                 push, keep_c;
  bpc_stack_t           stk_w, stk_r;

  // Wrapping increment inside twelve bits
  function automatic logic [`BPC_PC_W-1:0] pc_inc(input logic [`BPC_PC_W-1:0] pc,
                                                   input logic two);
    pc_inc = pc + (two ? 12'h002 : 12'h001);
  endfunction

  // Next counter and bank; bank moves only on a port-A write
  always_comb begin
    pc_nxt   = pc_r;
    bank_nxt = bank_r;
    cr_nxt   = cr_r;
    crv_nxt  = 1'b0;
    push     = 1'b0;
    keep_c   = 1'b0;
    stk_w.pc    = pc_inc(pc_r, cmd.two_word); // Return lands after the call
    stk_w.carry = carry_in;
    if (cycle_en) begin
      if (write_output_port_a) bank_nxt = acc[`BPC_BANK_BIT];
      case (cmd.op)
        BPC_OP_SEQ:  pc_nxt = pc_inc(pc_r, cmd.two_word);
        BPC_OP_JUMP: begin
          pc_nxt = cmd.target;
          push   = cmd.push;
        end
        BPC_OP_COND: begin
          if (cmd.taken) pc_nxt = {pc_r[`BPC_PC_W-1], cmd.target[`BPC_PC_W-2:0]};
          else pc_nxt = pc_inc(pc_r, cmd.two_word);
        end
        BPC_OP_RET:  pc_nxt = stk_r.pc;
        BPC_OP_RETURN_FROM_INTERRUPT: begin
          pc_nxt  = stk_r.pc;
          cr_nxt  = stk_r.carry;
          crv_nxt = 1'b1;
        end
        BPC_OP_TIMER: begin
          stk_w.pc = pc_r; // Interrupt resumes the pending instruction
          pc_nxt = `BPC_TIMER_VEC;
          push   = 1'b1;
          keep_c = 1'b1;
        end
        BPC_OP_EXT: begin
          stk_w.pc = pc_r;
          pc_nxt = `BPC_EXT_VEC;
          push   = 1'b1;
          keep_c = 1'b1;
        end
        default: pc_nxt = pc_r;
      endcase
    end
  end

  // State registers; reset wins over every load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r   <= `BPC_RESET_PC;
      bank_r <= `BPC_RESET_BANK;
      cr_r   <= 1'b0;
      crv_r  <= 1'b0;
    end else begin
      pc_r   <= pc_nxt;
      bank_r <= bank_nxt;
      cr_r   <= cr_nxt;
      crv_r  <= crv_nxt;
    end
  end

  bpc_stack u_stack (
    .clk    (clk),
    .rst_n  (rst_n),
    .push   (push),
    .keep_c (keep_c),
    .wdata  (stk_w),
    .rdata  (stk_r)
  );

  // Outputs straight from flops; bank bit on top of the address
  assign rom_addr          = {bank_r, pc_r};
  assign program_counter   = pc_r;
  assign rom_bank_select   = bank_r;
  assign carry_restore     = cr_r;
  assign carry_restore_vld = crv_r;

  // Assertions
  property p_bank_hold;
    @(posedge clk) disable iff (!rst_n)
      !(cycle_en && write_output_port_a) |=> $stable(bank_r);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved without port write");

  property p_bank_load;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && write_output_port_a) |=> bank_r == $past(acc[3]);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank not loaded");

  property p_seq;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_SEQ) |=>
        pc_r == $past(pc_r) + ($past(cmd.two_word) ? 12'h002 : 12'h001);
  endproperty
  a_seq: assert property (p_seq) else $error("bad increment");

  property p_jump;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_JUMP) |=> pc_r == $past(cmd.target);
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump");

  property p_cond;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_COND && cmd.taken) |=>
        pc_r[11] == $past(pc_r[11]) && pc_r[10:0] == $past(cmd.target[10:0]);
  endproperty
  a_cond: assert property (p_cond) else $error("bad branch");

  property p_ret;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_JUMP && cmd.push) ##1 (cycle_en && cmd.op == BPC_OP_RET)
        |=> pc_r == $past(pc_r, 2) + ($past(cmd.two_word, 2) ? 12'h002 : 12'h001);
  endproperty
  a_ret: assert property (p_ret) else $error("bad return");

  property p_timer;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_TIMER) |=> pc_r == 12'h004 &&
        bank_r == ($past(write_output_port_a) ? $past(acc[3]) : $past(bank_r));
  endproperty
  a_timer: assert property (p_timer) else $error("bad timer vector");

  property p_ext;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_EXT) |=> pc_r == 12'h008 &&
        bank_r == ($past(write_output_port_a) ? $past(acc[3]) : $past(bank_r));
  endproperty
  a_ext: assert property (p_ext) else $error("bad ext vector");

  property p_idle;
    @(posedge clk) disable iff (!rst_n)
      !cycle_en |=> $stable(pc_r);
  endproperty
  a_idle: assert property (p_idle) else $error("pc moved off boundary");

  // Return paths read the single stack entry
  property p_ret_load;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_RET) |=> pc_r == $past(stk_r.pc);
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("return missed stack");

  property p_return_from_interrupt_load;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_RETURN_FROM_INTERRUPT) |=>
        crv_r && pc_r == $past(stk_r.pc) && cr_r == $past(stk_r.carry);
  endproperty
  a_return_from_interrupt_load: assert property (p_return_from_interrupt_load) else $error("bad interrupt return");

  property p_int_return_from_interrupt;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_TIMER) ##1 (cycle_en && cmd.op == BPC_OP_RETURN_FROM_INTERRUPT)
        |=> cr_r == $past(carry_in, 2) && pc_r == $past(pc_r, 2);
  endproperty
  a_int_return_from_interrupt: assert property (p_int_return_from_interrupt) else $error("carry not restored");

  // Restore strobe lasts one cycle only
  property p_vld_pulse;
    @(posedge clk) disable iff (!rst_n)
      !(cycle_en && cmd.op == BPC_OP_RETURN_FROM_INTERRUPT) |=> !crv_r;
  endproperty
  a_vld_pulse: assert property (p_vld_pulse) else $error("stray restore strobe");

  // An unknown code must leave counter and stack alone
  property p_unknown;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == bpc_op_t'(3'h7)) |=> $stable(pc_r) && $stable(stk_r);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code moved state");

  // What calls and interrupts leave on the stack, and branch fall-through
  property p_call_push;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_JUMP && cmd.push) |=> $stable(stk_r.carry) &&
        stk_r.pc == $past(pc_r) + ($past(cmd.two_word) ? 12'h002 : 12'h001);
  endproperty
  a_call_push: assert property (p_call_push) else $error("bad call push");

  property p_int_push;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && (cmd.op == BPC_OP_TIMER || cmd.op == BPC_OP_EXT)) |=>
        stk_r.pc == $past(pc_r) && stk_r.carry == $past(carry_in);
  endproperty
  a_int_push: assert property (p_int_push) else $error("bad interrupt push");

  property p_cond_nt;
    @(posedge clk) disable iff (!rst_n)
      (cycle_en && cmd.op == BPC_OP_COND && !cmd.taken) |=>
        pc_r == $past(pc_r) + ($past(cmd.two_word) ? 12'h002 : 12'h001);
  endproperty
  a_cond_nt: assert property (p_cond_nt) else $error("bad branch fall-through");

  c_bank:  cover property (@(posedge clk) cycle_en && write_output_port_a);
  c_return_from_interrupt:  cover property (@(posedge clk) crv_r);
  c_wrap:  cover property (@(posedge clk) pc_r == 12'hFFF && cycle_en && cmd.op == BPC_OP_SEQ);
  c_int:   cover property (@(posedge clk)
    (cycle_en && cmd.op == BPC_OP_TIMER) ##1 (cycle_en && cmd.op == BPC_OP_RETURN_FROM_INTERRUPT));
  c_call:  cover property (@(posedge clk)
    (cycle_en && cmd.op == BPC_OP_JUMP && cmd.push) ##1 (cycle_en && cmd.op == BPC_OP_RET));
endmodule
`default_nettype wire

// ---- tb/bpc_rom_model.sv ----
// Program ROM model answering the banked address
`timescale 1ns/1ns
`default_nettype none
module bpc_rom_model (
  input  wire logic        clk,  // System clock
  input  wire logic [12:0] addr, // Bank bit and counter
  output logic      [7:0]  data  // Instruction word
);
  // Pattern mixes the bank bit in, so a wrong bank reads a different word
  always_ff @(posedge clk) begin
    data <= addr[7:0] ^ {addr[12], addr[11:5]};
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the banked program counter
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bpc_pkg::*;
  typedef struct packed {logic [12:0] a; logic v; logic c; logic ok;} bpc_exp_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cycle_en = 1'b0;
  bpc_cmd_t    cmd = '0;
  logic        wpa = 1'b0;
  logic [3:0]  acc = 4'h0;
  logic        carry_in = 1'b0;
  logic [12:0] rom_addr;
  logic [11:0] pc_o;
  logic        bank_o;
  logic        crst;
  logic        crst_vld;
  logic        cyc_d = 1'b0;
  logic [7:0]  rom_data;
  logic        bank_m = 1'b1;
  logic [11:0] pc_m = 12'h000;
  logic [11:0] stk_m = 12'h000;
  logic        stc_m = 1'b0;
  logic        ok_m = 1'b0;
  logic [12:0] a_d = 13'h0000;
  logic        ad_v = 1'b0;
  logic [31:0] r;
  int          err_count = 0;
  int          n_compared = 0;
  bpc_exp_t    exp_q[$];
  always #2 clk = ~clk;
  bpc_top dut (.clk(clk), .rst_n(rst_n), .cycle_en(cycle_en), .cmd(cmd),
    .write_output_port_a(wpa), .acc(acc), .carry_in(carry_in), .rom_addr(rom_addr),
    .program_counter(pc_o), .rom_bank_select(bank_o), .carry_restore(crst),
    .carry_restore_vld(crst_vld));
  bpc_rom_model rom (.clk(clk), .addr(rom_addr), .data(rom_data));
  task chk(input logic [12:0] seen, input logic [12:0] expv);
    n_compared++;
    if (seen !== expv) begin
      err_count++;
      $display("FAIL %0t saw %h expected %h", $time, seen, expv);
    end
  endtask
  task end_of_test;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Drive one accepted command and note what the counter must become
  task step(input bpc_op_t op, input logic [3:0] f, input logic [11:0] tg,
            input logic w, input logic [3:0] a, input logic c);
    logic [11:0] nx;
    logic        v;
    nx = pc_m + (f[1] ? 12'h002 : 12'h001);
    v = 1'b0;
    case (op)
      BPC_OP_SEQ: pc_m = nx;
      BPC_OP_JUMP: begin
        if (f[0]) begin
          stk_m = nx;
          ok_m = 1'b0;
        end
        pc_m = tg;
      end
      BPC_OP_COND: pc_m = f[2] ? {pc_m[11], tg[10:0]} : nx;
      BPC_OP_RET: pc_m = stk_m;
      BPC_OP_RETURN_FROM_INTERRUPT: begin
        pc_m = stk_m;
        v = 1'b1;
      end
      BPC_OP_TIMER, BPC_OP_EXT: begin
        stk_m = pc_m;
        stc_m = c;
        ok_m = 1'b1;
        pc_m = (op == BPC_OP_TIMER) ? 12'h004 : 12'h008;
      end
      default: pc_m = pc_m;
    endcase
    if (w) bank_m = a[3];
    @(posedge clk);
    cycle_en <= 1'b1;
    cmd <= '{op, f[0], f[1], f[2], tg};
    wpa <= w;
    acc <= a;
    carry_in <= c;
    exp_q.push_back('{{bank_m, pc_m}, v, stc_m, ok_m});
  endtask
  // Results land one edge after each accepted command
  always @(posedge clk) cyc_d <= cycle_en;
  always @(negedge clk) begin
    bpc_exp_t e;
    // ROM word one cycle later must be the one of the expected bank and address
    if (ad_v) chk({5'h00, rom_data}, {5'h00, a_d[7:0] ^ {a_d[12], a_d[11:5]}});
    ad_v = cyc_d;
    if (cyc_d) begin
      e = exp_q.pop_front();
      a_d = e.a;
      chk(rom_addr, e.a);
      chk({1'b0, pc_o}, {1'b0, e.a[11:0]});
      chk({12'h000, bank_o}, {12'h000, e.a[12]});
      chk({12'h000, crst_vld}, {12'h000, e.v});
      if (e.v && e.ok) chk({12'h000, crst}, {12'h000, e.c});
    end
  end
  // Reset, a wrap at the top of a bank, then random traffic with idle gaps
  initial begin
    void'($urandom(32'h4aba106c));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(rom_addr, 13'h1000);
    step(BPC_OP_JUMP, 4'h1, 12'hFFF, 1'b1, 4'h0, 1'b0);
    step(BPC_OP_SEQ, 4'h2, 12'h000, 1'b0, 4'h8, 1'b0);
    for (int i = 0; i < 600; i++) begin
      r = $urandom;
      if (r[31:30] == 2'b00) begin
        // Ignored cycle: garbage on the command must not move anything
        @(posedge clk);
        cycle_en <= 1'b0;
        wpa <= 1'b0;
        cmd.target <= r[11:0];
      end
      step(bpc_op_t'($urandom_range(7)), r[3:0], r[17:6], &r[19:18], r[23:20], r[24]);
    end
    @(posedge clk);
    cycle_en <= 1'b0;
    // Reset in mid-run lands on a live call; reset must win over the load
    @(posedge clk);
    rst_n <= 1'b0;
    cycle_en <= 1'b1;
    cmd <= '{BPC_OP_JUMP, 1'b1, 1'b0, 1'b0, 12'h5A5};
    exp_q.push_back('{13'h1000, 1'b0, 1'b0, 1'b0});
    @(posedge clk);
    cycle_en <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    pc_m = 12'h000;
    bank_m = 1'b1;
    ok_m = 1'b0;
    // Call, return, interrupt and interrupt return right after release
    step(BPC_OP_JUMP, 4'h3, 12'h7F0, 1'b0, 4'h0, 1'b0);
    step(BPC_OP_RET, 4'h0, 12'h000, 1'b0, 4'h0, 1'b0);
    step(BPC_OP_TIMER, 4'h0, 12'h000, 1'b0, 4'h0, 1'b1);
    step(BPC_OP_RETURN_FROM_INTERRUPT, 4'h0, 12'h000, 1'b0, 4'h0, 1'b0);
    @(posedge clk);
    cycle_en <= 1'b0;
    repeat (2) @(negedge clk);
    end_of_test;
  end
endmodule
`default_nettype wire
